// ==== pkg/tmc_pkg.sv ====
package tmc_pkg;

  // Bus and data widths.
  localparam int WB_ADR_W = 10;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int REG_W    = 8;
  localparam int TEMP_W   = 10;
  localparam int NUM_FAN  = 4;
  localparam int NUM_CH   = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_GATE_TREE = 8'h6F;
  localparam logic [7:0] IDX_R1_OFS    = 8'h70;
  localparam logic [7:0] IDX_LOC_OFS   = 8'h71;
  localparam logic [7:0] IDX_R2_OFS    = 8'h72;
  localparam logic [7:0] IDX_CFG2      = 8'h73;
  localparam logic [7:0] IDX_LOCK      = 8'h40;
  localparam logic [7:0] IDX_STATUS    = 8'h41;
  localparam logic [7:0] IDX_RESULT0   = 8'h42;

  // Reset values.
  localparam logic [7:0] RST_GATE_TREE = 8'h00;
  localparam logic [7:0] RST_OFS       = 8'h00;
  localparam logic [7:0] RST_CFG2      = 8'h00;
  localparam logic       RST_LOCK      = 1'b0;

  // Field positions.
  localparam int GATE_TREE_EN_BIT = 0;
  localparam int LOCK_BIT         = 0;
  localparam int TWO_WIRE_LSB     = 0;
  localparam int AVG_OFF_BIT      = 4;
  localparam int ATTENUATOR_BYPASS_BYP_BIT     = 5;
  localparam int CFG2_W           = 6;
  localparam int ST_LOCK_BIT      = 0;
  localparam int ST_GATE_BIT      = 1;
  localparam int ST_LOWF_BIT      = 2;
  localparam int ST_TWO_WIRE_LSB  = 4;

  // Channel order follows the offset registers.
  localparam int CH_REMOTE1 = 0;
  localparam int CH_LOCAL   = 1;
  localparam int CH_REMOTE2 = 2;

  // Temperature sample with its strobe; value in quarter degrees.
  typedef struct packed {
    logic                     valid;
    logic signed [TEMP_W-1:0] value;
  } tmc_temp_s;

  // Classic Wishbone request.
  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [WB_ADR_W-1:0] adr;
    logic [WB_SEL_W-1:0] sel;
    logic [WB_DAT_W-1:0] dat;
  } tmc_wb_req_s;

endpackage

// ==== src/tmc_offset_add.sv ====
`timescale 1ns/1ps
module tmc_offset_add
  import tmc_pkg::*;
#(
  parameter int RAW_W = TEMP_W,
  parameter int OFS_W = REG_W
) (
  // Operands.
  input  wire logic signed [RAW_W-1:0] i_raw,
  input  wire logic signed [OFS_W-1:0] i_ofs,
  // Result.
  output logic signed [RAW_W-1:0]      o_sum
);

  localparam int SUM_W = RAW_W + 2;
  localparam logic signed [SUM_W-1:0] MAX_V = SUM_W'((1 <<< (RAW_W - 1)) - 1);
  localparam logic signed [SUM_W-1:0] MIN_V = -SUM_W'(1 <<< (RAW_W - 1));

  logic signed [SUM_W-1:0] ofs_q;
  logic signed [SUM_W-1:0] sum;

  // The offset counts half degrees, the raw value quarter degrees.
  always_comb begin
    ofs_q = SUM_W'(i_ofs) <<< 1;
    sum   = SUM_W'(i_raw) + ofs_q;
    if (sum > MAX_V) begin
      o_sum = MAX_V[RAW_W-1:0];
    end else if (sum < MIN_V) begin
      o_sum = MIN_V[RAW_W-1:0];
    end else begin
      o_sum = sum[RAW_W-1:0];
    end
  end

endmodule // tmc_offset_add

// ==== src/tmc_top.sv ====
//Function
// R1: Gate-tree test bit enters or leaves test mode
// R2: Host never writes reserved test bits
// R3: Lock makes these registers read-only
// R4: Remote 1 offset added, half-degree steps
// R5: Local offset added, half-degree steps
// R6: Remote 2 offset added, half-degree steps
// R7: Second config register resets to zero
// R8: Bits 0-3 pick 2-wire or 3-wire sensing
// R9: 2-wire selection acts only in low frequency
// R10: 2-wire inputs take the fourth config threshold
// R11: Bit 4 turns measurement averaging off
// R12: Bit 5 bypasses processor supply attenuator
// R13: Reserved test bits read zero, no effect
`timescale 1ns/1ps
module tmc_top
  import tmc_pkg::*;
#(
  parameter int NUM_FANS  = NUM_FAN,
  parameter int NUM_CHANS = NUM_CH
) (
  // Clock and reset.
  input  wire logic                            I_MCLK,
  input  wire logic                            I_RST_N,
  // Wishbone slave.
  input  wire logic                            I_WB_CYC,
  input  wire logic                            I_WB_STB,
  input  wire logic                            I_WB_WE,
  input  wire logic [WB_ADR_W-1:0]             I_WB_ADR,
  input  wire logic [WB_SEL_W-1:0]             I_WB_SEL,
  input  wire logic [WB_DAT_W-1:0]             I_WB_DAT,
  output logic      [WB_DAT_W-1:0]             O_WB_DAT,
  output logic                                 O_WB_ACK,
  // Fan sensing context.
  input  wire logic                            I_FAN_LOW_FREQ,
  input  wire logic [REG_W-1:0]                I_TWO_WIRE_THRESH,
  // Temperature results.
  input  wire tmc_temp_s [NUM_CHANS-1:0]       I_TEMP_RAW,
  output tmc_temp_s      [NUM_CHANS-1:0]       O_TEMP_CORR,
  // Mode controls.
  output logic                                 O_GATE_TREE_TEST,
  output logic      [NUM_FANS-1:0]             O_TWO_WIRE_SENSE,
  output logic      [NUM_FANS-1:0][REG_W-1:0]  O_FAN_THRESH,
  output logic                                 O_AVERAGING_OFF,
  output logic                                 O_ATTENUATOR_BYPASS
);

  typedef struct packed {
    logic                                ack;
    logic [WB_DAT_W-1:0]                 rdat;
    logic                                gate_tree_test_en;
    logic [NUM_CHANS-1:0][REG_W-1:0]     ofs;
    logic [CFG2_W-1:0]                   cfg2;
    logic                                lock;
    logic [NUM_FANS-1:0]                 two_wire;
    logic [NUM_FANS-1:0][REG_W-1:0]      thresh;
    tmc_temp_s [NUM_CHANS-1:0]           temp;
  } tmc_state_s;

  logic        rst_meta_n;
  logic        rst_n;
  tmc_wb_req_s req;
  tmc_state_s  st;
  tmc_state_s  next_st;
  logic [NUM_CHANS-1:0][TEMP_W-1:0] corr;
  logic [7:0]  idx;
  logic        launch;
  logic        commit;

  // Reset release goes through two flip-flops.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  assign req.cyc = I_WB_CYC;
  assign req.stb = I_WB_STB;
  assign req.we  = I_WB_WE;
  assign req.adr = I_WB_ADR;
  assign req.sel = I_WB_SEL;
  assign req.dat = I_WB_DAT;

  // Word index of a byte address.
  function automatic logic [7:0] word_index(input logic [WB_ADR_W-1:0] adr);
    word_index = adr[WB_ADR_W-1:2];
  endfunction

  // Registers that the lock freezes.
  function automatic logic is_lockable(input logic [7:0] i);
    is_lockable = (i >= IDX_GATE_TREE) && (i <= IDX_CFG2);
  endfunction

  // True for the index of an offset register.
  function automatic logic is_offset(input logic [7:0] i);
    is_offset = (i >= IDX_R1_OFS) && (i <= IDX_R2_OFS);
  endfunction

  // Read data for an index; unmapped reads return zero.
  function automatic logic [WB_DAT_W-1:0] read_word(input logic [7:0] i, input tmc_state_s s,
                                                     input logic lowf);
    logic [WB_DAT_W-1:0] w;
    logic [7:0]          rel;
    w   = '0;
    rel = i - IDX_RESULT0;
    if (i == IDX_GATE_TREE) begin
      w[GATE_TREE_EN_BIT] = s.gate_tree_test_en; // R13
    end else if (is_offset(i)) begin
      w[REG_W-1:0] = s.ofs[i - IDX_R1_OFS];
    end else if (i == IDX_CFG2) begin
      w[CFG2_W-1:0] = s.cfg2;
    end else if (i == IDX_LOCK) begin
      w[LOCK_BIT] = s.lock;
    end else if (i == IDX_STATUS) begin
      w[ST_LOCK_BIT] = s.lock;
      w[ST_GATE_BIT] = s.gate_tree_test_en;
      w[ST_LOWF_BIT] = lowf;
      w[ST_TWO_WIRE_LSB +: NUM_FANS] = s.two_wire;
    end else if (rel < 8'(NUM_CHANS)) begin
      w[TEMP_W-1:0] = s.temp[rel].value;
    end
    read_word = w;
  endfunction

  // Offset adders, one per temperature channel.
  generate
    for (genvar c = 0; c < NUM_CHANS; c++) begin : g_ofs
      tmc_offset_add #(
        .RAW_W (TEMP_W),
        .OFS_W (REG_W)
      ) u_add (
        .i_raw (I_TEMP_RAW[c].value),
        .i_ofs (st.ofs[c]),
        .o_sum (corr[c])
      );
    end
  endgenerate

  assign idx    = word_index(req.adr);
  assign launch = req.cyc && req.stb && !st.ack;
  assign commit = req.cyc && req.stb && st.ack && req.we && req.sel[0];

  always_comb begin
    next_st = st;

    // Acknowledge one cycle after the request; drop it the cycle after.
    next_st.ack  = launch;
    next_st.rdat = launch ? read_word(idx, st, I_FAN_LOW_FREQ) : '0;

    // Writes take effect at the edge that sees the acknowledge.
    if (commit) begin
      if (idx == IDX_LOCK) begin
        next_st.lock = st.lock | req.dat[LOCK_BIT];
      end else if (is_lockable(idx) && !st.lock) begin // R3
        if (idx == IDX_GATE_TREE) begin
          next_st.gate_tree_test_en = req.dat[GATE_TREE_EN_BIT]; // R1 R13
        end else if (is_offset(idx)) begin
          next_st.ofs[idx - IDX_R1_OFS] = req.dat[REG_W-1:0];
        end else begin
          next_st.cfg2 = req.dat[CFG2_W-1:0];
        end
      end
    end

    // Two-wire sensing is honoured only in low frequency drive.
    for (int f = 0; f < NUM_FANS; f++) begin
      next_st.two_wire[f] = st.cfg2[TWO_WIRE_LSB + f] && I_FAN_LOW_FREQ; // R8 R9
      next_st.thresh[f]   = next_st.two_wire[f] ? I_TWO_WIRE_THRESH : '0; // R10
    end

    // Corrected results follow each raw result by one cycle.
    for (int c = 0; c < NUM_CHANS; c++) begin
      next_st.temp[c].valid = I_TEMP_RAW[c].valid;
      if (I_TEMP_RAW[c].valid) begin
        next_st.temp[c].value = corr[c]; // R4 R5 R6
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      st                   <= '0;
      st.gate_tree_test_en <= RST_GATE_TREE[GATE_TREE_EN_BIT];
      st.ofs               <= {NUM_CHANS{RST_OFS}};
      st.cfg2              <= RST_CFG2[CFG2_W-1:0]; // R7
      st.lock              <= RST_LOCK;
    end else begin
      st <= next_st;
    end
  end

  assign O_WB_ACK            = st.ack;
  assign O_WB_DAT            = st.rdat;
  assign O_GATE_TREE_TEST    = st.gate_tree_test_en; // R1
  assign O_TWO_WIRE_SENSE    = st.two_wire;
  assign O_FAN_THRESH        = st.thresh;
  assign O_AVERAGING_OFF     = st.cfg2[AVG_OFF_BIT]; // R11
  assign O_ATTENUATOR_BYPASS = st.cfg2[ATTENUATOR_BYPASS_BYP_BIT]; // R12
  assign O_TEMP_CORR         = st.temp;

endmodule // tmc_top

// ==== verification/tmc_assertions.sv ====
`timescale 1ns/1ps
module tmc_checker
  import tmc_pkg::*;
#(
  parameter int NUM_FANS  = NUM_FAN,
  parameter int NUM_CHANS = NUM_CH
) (
  // Watched ports.
  input wire logic                            I_MCLK, I_RST_N, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK,
  input wire logic                            I_FAN_LOW_FREQ, O_GATE_TREE_TEST, O_AVERAGING_OFF,
  input wire logic [WB_ADR_W-1:0]             I_WB_ADR,
  input wire logic [WB_SEL_W-1:0]             I_WB_SEL,
  input wire logic [WB_DAT_W-1:0]             I_WB_DAT,
  input wire logic [REG_W-1:0]                I_TWO_WIRE_THRESH,
  input wire tmc_temp_s [NUM_CHANS-1:0]       I_TEMP_RAW, O_TEMP_CORR,
  input wire logic [NUM_FANS-1:0]             O_TWO_WIRE_SENSE,
  input wire logic [NUM_FANS-1:0][REG_W-1:0]  O_FAN_THRESH
);
  logic       lk;
  logic       wr;
  logic [7:0] ix;
  assign wr = O_WB_ACK && I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0];
  assign ix = I_WB_ADR[WB_ADR_W-1:2];
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) lk <= 1'b0;
    else if (wr && ix == IDX_LOCK && I_WB_DAT[LOCK_BIT]) lk <= 1'b1;
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack too long");
  a_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("no ack");
  a_gate_follow: assert property (wr && ix == IDX_GATE_TREE && !lk |-> ##2
    O_GATE_TREE_TEST == $past(I_WB_DAT[GATE_TREE_EN_BIT], 2))
    else $error("test bit");
  a_avg_follow: assert property (wr && ix == IDX_CFG2 && !lk |-> ##2
    O_AVERAGING_OFF == $past(I_WB_DAT[AVG_OFF_BIT], 2))
    else $error("avg bit");
  a_lock_hold: assert property (lk && wr && ix >= IDX_GATE_TREE && ix <= IDX_CFG2 |-> ##2
    O_GATE_TREE_TEST == $past(O_GATE_TREE_TEST, 2) && O_AVERAGING_OFF == $past(O_AVERAGING_OFF, 2))
    else $error("locked write");
  a_two_wire_gate: assert property (|O_TWO_WIRE_SENSE |-> $past(I_FAN_LOW_FREQ))
    else $error("two wire");
  a_thresh_route: assert property ((O_TWO_WIRE_SENSE[0] && $stable(I_TWO_WIRE_THRESH)) [*2] |->
    O_FAN_THRESH[0] == I_TWO_WIRE_THRESH) else $error("thresh");
  a_temp_valid: assert property (I_TEMP_RAW[0].valid |=> O_TEMP_CORR[0].valid)
    else $error("temp valid");
endmodule // tmc_checker
bind tmc_top tmc_checker #(.NUM_FANS(NUM_FANS), .NUM_CHANS(NUM_CHANS)) u_tmc_checker (.I_MCLK, .I_RST_N,
  .I_WB_CYC, .I_WB_STB, .I_WB_WE, .O_WB_ACK, .I_FAN_LOW_FREQ, .O_GATE_TREE_TEST, .O_AVERAGING_OFF,
  .I_WB_ADR, .I_WB_SEL, .I_WB_DAT, .I_TWO_WIRE_THRESH, .I_TEMP_RAW, .O_TEMP_CORR, .O_TWO_WIRE_SENSE,
  .O_FAN_THRESH);

// ==== verification/tmc_tb.sv ====
`timescale 1ns/1ps
module tmc_tb
  import tmc_pkg::*;
;
  logic clk, rst_n, cyc, stb, we, lowf, ack, gate, averaging_off, attenuator_bypass;
  logic [WB_ADR_W-1:0] adr;
  logic [WB_SEL_W-1:0] sel;
  logic [WB_DAT_W-1:0] dat, rdat;
  logic [REG_W-1:0] thr;
  logic [NUM_FAN-1:0] two;
  logic [NUM_FAN-1:0][REG_W-1:0] fthr;
  tmc_temp_s [NUM_CH-1:0] traw, tcorr;
  int mismatches, checks_done;
  tmc_top u_tmc_top (.I_MCLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_FAN_LOW_FREQ(lowf),
    .I_TWO_WIRE_THRESH(thr), .I_TEMP_RAW(traw), .O_TEMP_CORR(tcorr), .O_GATE_TREE_TEST(gate),
    .O_TWO_WIRE_SENSE(two), .O_FAN_THRESH(fthr), .O_AVERAGING_OFF(averaging_off), .O_ATTENUATOR_BYPASS(attenuator_bypass));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    dat <= {24'h00_0000, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, ix, d, q);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, ix, 8'h00, q);
    chk(q, e);
  endtask
  task automatic look();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    {rst_n, cyc, stb, we, lowf, adr, dat, traw} = '0;
    sel = 4'h1;
    thr = 8'hA5;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 5; i++) rd(IDX_GATE_TREE + 8'(i), 32'h0000_0000);
    chk({gate, averaging_off, attenuator_bypass, two}, 32'h0000_0000);
    wr(IDX_GATE_TREE, 8'h01);
    rd(IDX_GATE_TREE, 32'h0000_0001);
    look();
    chk(gate, 32'h0000_0001);
    wr(IDX_GATE_TREE, 8'h00);
    look();
    chk(gate, 32'h0000_0000);
    wr(IDX_CFG2, 8'h3F);
    look();
    chk({averaging_off, attenuator_bypass, two}, 32'h0000_0030);
    chk(fthr, 32'h0000_0000);
    @(posedge clk);
    lowf <= 1'b1;
    look();
    chk(two, 32'h0000_000F);
    chk(fthr, {4{thr}});
    wr(IDX_CFG2, 8'h05);
    look();
    chk({averaging_off, attenuator_bypass, two}, 32'h0000_0005);
    chk(fthr, {8'h00, thr, 8'h00, thr});
    rd(IDX_CFG2, 32'h0000_0005);
    wr(IDX_R1_OFS, 8'h04);
    wr(IDX_LOC_OFS, 8'hFC);
    wr(IDX_R2_OFS, 8'h7F);
    @(posedge clk);
    traw <= {1'b1, 10'h190, 1'b1, 10'h000, 1'b1, 10'h064};
    @(posedge clk);
    traw <= '0;
    @(negedge clk);
    chk(tcorr[0], {1'b1, 10'h06C});
    chk(tcorr[1], {1'b1, 10'h3F8});
    chk(tcorr[2], {1'b1, 10'h1FF});
    rd(IDX_RESULT0, 32'h0000_006C);
    rd(IDX_RESULT0 + 8'h01, 32'h0000_03F8);
    rd(IDX_RESULT0 + 8'h02, 32'h0000_01FF);
    wr(IDX_LOCK, 8'h01);
    wr(IDX_GATE_TREE, 8'h01);
    wr(IDX_R1_OFS, 8'h55);
    wr(IDX_CFG2, 8'h10);
    rd(IDX_R1_OFS, 32'h0000_0004);
    look();
    chk({gate, averaging_off, two}, 32'h0000_0005);
    rd(IDX_LOCK, 32'h0000_0001);
    rd(IDX_STATUS, 32'h0000_0055);
    wr(8'h50, 8'hFF);
    rd(8'h50, 32'h0000_0000);
    wrap_up();
  end
endmodule // tmc_tb
